// File: hdl/bpu_core.sv
// Bit processor and program flow execution unit
`timescale 1ns/10ps
module bpu_core
  import bpu_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        opValid,
  input  wire bpu_op_t     opCode,
  input  wire logic [7:0]  opBitAdr,
  input  wire logic [7:0]  opRel,
  input  wire logic [15:0] opTarget,
  input  wire logic [7:0]  opByte,
  input  wire logic [7:0]  opByte2,
  input  wire logic [15:0] pcNext,
  input  wire logic [7:0]  accIn,
  input  wire logic [15:0] ptrIn,
  input  wire logic [15:0] retAddr,
  input  wire logic [7:0]  memRdata,
  input  wire logic        carryIn,
  output logic             opReady,
  output logic [7:0]       memAddr,
  output logic             memWe,
  output logic [7:0]       memWdata,
  output logic             carryWe,
  output logic             carryOut,
  output logic             pcWe,
  output logic [15:0]      pcOut,
  output logic             pushPc,
  output logic             popPc,
  output logic             intDone,
  output logic             byteWe,
  output logic [7:0]       byteOut,
  output logic             done
);
  // ==========================================
  // Submodules
  logic      mcTick;
  bpu_mem_if mem ();
  bpu_mc_timer u_timer (.clk_sys(clk_sys), .rst_n(rst_n), .mcTick(mcTick));
  bpu_bit_access u_bits (.mem(mem));
  assign mem.rdByte = memRdata;

  // ==========================================
  // Sequencer
  bpu_state_t  st_q, st_d;
  bpu_op_t     op_q, op_d;
  logic [7:0]  bit_q, bit_d, rel_q, rel_d, b1_q, b1_d, b2_q, b2_d;
  logic [15:0] tgt_q, tgt_d, pcn_q, pcn_d;
  logic [1:0]  mc_q, mc_d, need_q, need_d;
  logic        cy_q, cy_d;
  logic        memWe_q, memWe_d, carryWe_q, carryWe_d, carry_q, carry_d;
  logic        pcWe_q, pcWe_d, push_q, push_d, pop_q, pop_d, intd_q, intd_d;
  logic        bwe_q, bwe_d, done_q, done_d;
  logic [7:0]  wd_q, wd_d, bo_q, bo_d;
  logic [15:0] pc_q, pc_d;
  logic        isBitOp, takeBr, newBit;
  logic [7:0]  dec;

  function automatic logic [1:0] bpu_cycles(input bpu_op_t op);
    case (op)
      OP_MOV_C_BIT, OP_ZERO_C, OP_ZERO_BIT, OP_ONE_C, OP_ONE_BIT,
      OP_INV_C, OP_INV_BIT, OP_IDLE: bpu_cycles = MC_ONE;
      default:                       bpu_cycles = MC_TWO;
    endcase
  endfunction : bpu_cycles

  always_comb begin
    isBitOp = !(op_q inside {OP_IDLE, OP_ZERO_C, OP_ONE_C, OP_INV_C, OP_JFS, OP_JFC,
                             OP_SHORT_RELATIVE_JUMP, OP_LONG_JUMP, OP_PAGE_JUMP, OP_JIDX, OP_LONG_CALL, OP_PAGE_CALL,
                             OP_RET, OP_INTERRUPT_EXIT, OP_JZ, OP_JNZ, OP_DECREMENT_BRANCH, OP_COMPARE_BRANCH_UNEQUAL});
    // Carry bit of the status word is served from the live carry for OP_JBS, OP_JBC, OP_JBCLR and OP_INV_BIT, from RAM otherwise
    mem.bitAdr = bit_q;
    mem.wrBit  = 1'b0;
    dec        = b1_q - 8'h01;
    newBit     = mem.bitVal;
    takeBr     = 1'b0;
    st_d = st_q; op_d = op_q; bit_d = bit_q; rel_d = rel_q; tgt_d = tgt_q;
    b1_d = b1_q; b2_d = b2_q; pcn_d = pcn_q; mc_d = mc_q; need_d = need_q;
    cy_d = cy_q;
    memWe_d = 1'b0; carryWe_d = 1'b0; carry_d = carry_q; pcWe_d = 1'b0;
    push_d = 1'b0; pop_d = 1'b0; intd_d = 1'b0; bwe_d = 1'b0; done_d = 1'b0;
    wd_d = wd_q; bo_d = bo_q; pc_d = pc_q;
    case (op_q)
      OP_JBS, OP_JBCLR: takeBr = (bit_q == CARRY_BITADR) ? cy_q : mem.bitVal;
      OP_JBC:           takeBr = !((bit_q == CARRY_BITADR) ? cy_q : mem.bitVal);
      OP_JFS:           takeBr = cy_q;
      OP_JFC:           takeBr = !cy_q;
      OP_SHORT_RELATIVE_JUMP:          takeBr = 1'b1;
      OP_JZ:            takeBr = (b1_q == 8'h00);
      OP_JNZ:           takeBr = (b1_q != 8'h00);
      OP_DECREMENT_BRANCH:          takeBr = (dec != 8'h00);
      OP_COMPARE_BRANCH_UNEQUAL:          takeBr = (b1_q != b2_q);
      default:          takeBr = 1'b0;
    endcase
    case (op_q)
      OP_ZERO_BIT, OP_JBCLR: newBit = 1'b0;
      OP_ONE_BIT:            newBit = 1'b1;
      OP_INV_BIT:            newBit = !mem.bitVal;
      OP_MOV_BIT_C:          newBit = cy_q;
      default:               newBit = mem.bitVal;
    endcase
    mem.wrVal = newBit;
    case (st_q)
      ST_IDLE: begin
        if (opValid) begin
          op_d = opCode; bit_d = opBitAdr; rel_d = opRel; tgt_d = opTarget;
          pcn_d = pcNext; cy_d = carryIn; need_d = bpu_cycles(opCode); mc_d = 2'h0;
          b1_d = (opCode inside {OP_JZ, OP_JNZ}) ? accIn : opByte;
          b2_d = opByte2;
          if (opCode == OP_JIDX) tgt_d = ptrIn + {8'h00, accIn};
          st_d = ST_READ;
        end
      end
      ST_READ: begin
        if (mcTick) begin
          mc_d = mc_q + 2'h1;
          if (mc_q + 2'h1 == need_q) st_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        st_d = ST_DONE; done_d = 1'b1;
        case (op_q)
          OP_AND_BIT:   begin carry_d = cy_q & mem.bitVal;  carryWe_d = 1'b1; end
          OP_AND_NBIT:  begin carry_d = cy_q & !mem.bitVal; carryWe_d = 1'b1; end
          OP_OR_BIT:    begin carry_d = cy_q | mem.bitVal;  carryWe_d = 1'b1; end
          OP_OR_NBIT:   begin carry_d = cy_q | !mem.bitVal; carryWe_d = 1'b1; end
          OP_MOV_C_BIT: begin carry_d = mem.bitVal;         carryWe_d = 1'b1; end
          OP_ZERO_C:    begin carry_d = 1'b0;               carryWe_d = 1'b1; end
          OP_ONE_C:     begin carry_d = 1'b1;               carryWe_d = 1'b1; end
          OP_INV_C:     begin carry_d = !cy_q;              carryWe_d = 1'b1; end
          OP_LONG_JUMP:      begin pc_d = tgt_q; pcWe_d = 1'b1; end
          OP_PAGE_JUMP:      begin pc_d = {pcn_q[15:11], tgt_q[10:0] & PAGE_MASK}; pcWe_d = 1'b1; end
          OP_JIDX:      begin pc_d = tgt_q; pcWe_d = 1'b1; end
          OP_LONG_CALL:     begin pc_d = tgt_q; pcWe_d = 1'b1; push_d = 1'b1; end
          OP_PAGE_CALL:     begin
            pc_d = {pcn_q[15:11], tgt_q[10:0]}; pcWe_d = 1'b1; push_d = 1'b1;
          end
          OP_RET:       begin pc_d = retAddr; pcWe_d = 1'b1; pop_d = 1'b1; end
          OP_INTERRUPT_EXIT:      begin
            pc_d = retAddr; pcWe_d = 1'b1; pop_d = 1'b1; intd_d = 1'b1;
          end
          OP_DECREMENT_BRANCH:      begin bo_d = dec; bwe_d = 1'b1; end
          OP_COMPARE_BRANCH_UNEQUAL:      begin carry_d = (b1_q < b2_q); carryWe_d = 1'b1; end
          default:      ;
        endcase
        if (takeBr) begin
          pc_d = bpu_rel(pcn_q, rel_q);
          pcWe_d = 1'b1;
        end
        // Only the carry-directed bit address bypasses RAM
        if (isBitOp && newBit != mem.bitVal && bit_q != CARRY_BITADR &&
            op_q inside {OP_ZERO_BIT, OP_ONE_BIT, OP_INV_BIT, OP_MOV_BIT_C, OP_JBCLR}) begin
          memWe_d = 1'b1; wd_d = mem.wrByte;
        end
        if (isBitOp && bit_q == CARRY_BITADR &&
            op_q inside {OP_ZERO_BIT, OP_ONE_BIT, OP_INV_BIT, OP_MOV_BIT_C, OP_JBCLR}) begin
          carry_d = (op_q == OP_INV_BIT) ? !cy_q : newBit; carryWe_d = 1'b1;
        end
      end
      ST_DONE: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE; op_q <= OP_IDLE; bit_q <= 8'h00; rel_q <= 8'h00; tgt_q <= 16'h0000;
      b1_q <= 8'h00; b2_q <= 8'h00; pcn_q <= 16'h0000; mc_q <= 2'h0; need_q <= 2'h0;
      cy_q <= 1'b0; memWe_q <= 1'b0; carryWe_q <= 1'b0; carry_q <= 1'b0; pcWe_q <= 1'b0;
      push_q <= 1'b0; pop_q <= 1'b0; intd_q <= 1'b0; bwe_q <= 1'b0; done_q <= 1'b0;
      wd_q <= 8'h00; bo_q <= 8'h00; pc_q <= 16'h0000;
    end else begin
      st_q <= st_d; op_q <= op_d; bit_q <= bit_d; rel_q <= rel_d; tgt_q <= tgt_d;
      b1_q <= b1_d; b2_q <= b2_d; pcn_q <= pcn_d; mc_q <= mc_d; need_q <= need_d;
      cy_q <= cy_d; memWe_q <= memWe_d; carryWe_q <= carryWe_d; carry_q <= carry_d;
      pcWe_q <= pcWe_d; push_q <= push_d; pop_q <= pop_d; intd_q <= intd_d;
      bwe_q <= bwe_d; done_q <= done_d; wd_q <= wd_d; bo_q <= bo_d; pc_q <= pc_d;
    end
  end

  assign opReady  = (st_q == ST_IDLE);
  assign memAddr  = mem.byteAdr;
  assign memWe    = memWe_q;
  assign memWdata = wd_q;
  assign carryWe  = carryWe_q;
  assign carryOut = carry_q;
  assign pcWe     = pcWe_q;
  assign pcOut    = pc_q;
  assign pushPc   = push_q;
  assign popPc    = pop_q;
  assign intDone  = intd_q;
  assign byteWe   = bwe_q;
  assign byteOut  = bo_q;
  assign done     = done_q;

  // ==========================================
  // Checks
  property p_compare_branch_unequal_carry;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_EXEC && op_q == OP_COMPARE_BRANCH_UNEQUAL) |=> carryWe && (carryOut == (b1_q < b2_q));
  endproperty
  a_compare_branch_unequal_carry: assert property (p_compare_branch_unequal_carry) else $error("compare carry not written");
  property p_interrupt_exit_done;
    @(posedge clk_sys) disable iff (!rst_n) intDone |-> popPc && pcWe;
  endproperty
  a_interrupt_exit_done: assert property (p_interrupt_exit_done) else $error("interrupt exit without return");
  property p_page_jump_high;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_EXEC && op_q == OP_PAGE_JUMP) |=> pcOut[15:11] == $past(pcn_q[15:11]);
  endproperty
  a_page_jump_high: assert property (p_page_jump_high) else $error("page jump altered high bits");
  property p_one_cycle;
    @(posedge clk_sys) disable iff (!rst_n)
      (opValid && opReady && opCode == OP_IDLE) |-> ##[1:13] (st_q == ST_EXEC);
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("idle took too long");
  property p_two_cycle;
    @(posedge clk_sys) disable iff (!rst_n)
      (opValid && opReady && opCode == OP_LONG_JUMP) |-> ##[13:25] (st_q == ST_EXEC);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("jump timing wrong");
  property p_rel;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_EXEC && op_q == OP_SHORT_RELATIVE_JUMP) |=>
        pcWe && pcOut == ($past(pcn_q) + {{8{$past(rel_q[7])}}, $past(rel_q)});
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_decrement_branch;
    @(posedge clk_sys) disable iff (!rst_n)
      (st_q == ST_EXEC && op_q == OP_DECREMENT_BRANCH && b1_q == 8'h01) |=> !pcWe && byteOut == 8'h00;
  endproperty
  a_decrement_branch: assert property (p_decrement_branch) else $error("decrement branched on zero");
  property p_done;
    @(posedge clk_sys) disable iff (!rst_n) done |-> ##1 opReady;
  endproperty
  a_done: assert property (p_done) else $error("not ready after done");
  c_call: cover property (@(posedge clk_sys) pushPc);
  c_interrupt_exit: cover property (@(posedge clk_sys) intDone);
  c_bitw: cover property (@(posedge clk_sys) memWe);
endmodule : bpu_core

// File: pkg/bpu_pkg.sv
// Constants and types for the bit processor and branch unit
package bpu_pkg;
  // ==========================================
  // Timing
  localparam int unsigned CLK_NS        = 10;
  localparam int unsigned OSC_PER_MC    = 12;
  localparam logic [3:0]  MC_LAST       = 4'(OSC_PER_MC - 1);
  localparam logic [1:0]  MC_ONE        = 2'h1;
  localparam logic [1:0]  MC_TWO        = 2'h2;
  // ==========================================
  // Addressing
  localparam logic [7:0]  BIT_SFR_BASE  = 8'h80;
  localparam logic [7:0]  RAM_BIT_BYTE  = 8'h20;
  localparam logic [7:0]  PSW_ADDR      = 8'hD0;
  localparam logic [7:0]  CARRY_BITADR  = 8'hD7;
  localparam int unsigned CARRY_POS     = 7;
  localparam logic [10:0] PAGE_MASK     = 11'h7FF;
  // ==========================================
  // Operations
  typedef enum logic [4:0] {
    OP_IDLE, OP_AND_BIT, OP_AND_NBIT, OP_OR_BIT, OP_OR_NBIT, OP_MOV_C_BIT,
    OP_MOV_BIT_C, OP_ZERO_C, OP_ZERO_BIT, OP_ONE_C, OP_ONE_BIT, OP_INV_C,
    OP_INV_BIT, OP_JFS, OP_JFC, OP_JBS, OP_JBC, OP_JBCLR, OP_SHORT_RELATIVE_JUMP, OP_LONG_JUMP,
    OP_PAGE_JUMP, OP_JIDX, OP_LONG_CALL, OP_PAGE_CALL, OP_RET, OP_INTERRUPT_EXIT, OP_JZ, OP_JNZ,
    OP_DECREMENT_BRANCH, OP_COMPARE_BRANCH_UNEQUAL
  } bpu_op_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_EXEC = 4'h4,
    ST_DONE = 4'h8
  } bpu_state_t;

  function automatic logic [7:0] bpu_byte_of(input logic [7:0] bitAdr);
    bpu_byte_of = bitAdr[7] ? {bitAdr[7:3], 3'h0} : (RAM_BIT_BYTE + {3'h0, bitAdr[7:3]});
  endfunction : bpu_byte_of

  function automatic logic [15:0] bpu_rel(input logic [15:0] pc, input logic [7:0] ofs);
    bpu_rel = pc + {{8{ofs[7]}}, ofs};
  endfunction : bpu_rel
endpackage : bpu_pkg

// File: pkg/bpu_mem_if.sv
// Byte access channel between sequencer and bit access unit
`timescale 1ns/10ps
interface bpu_mem_if;
  logic [7:0] bitAdr;
  logic [7:0] byteAdr;
  logic [2:0] bitPos;
  logic       bitVal;
  logic [7:0] rdByte;
  logic       wrBit;
  logic       wrVal;
  logic [7:0] wrByte;
  modport seq (output bitAdr, output wrBit, output wrVal, input bitVal, input byteAdr,
               input wrByte);
  modport acc (input bitAdr, input wrBit, input wrVal, input rdByte, output bitVal,
               output byteAdr, output bitPos, output wrByte);
endinterface : bpu_mem_if

// File: hdl/bpu_bit_access.sv
// Maps a bit address to byte and merges a bit into that byte
`timescale 1ns/10ps
module bpu_bit_access
  import bpu_pkg::*;
(
  bpu_mem_if.acc mem
);
  always_comb begin
    mem.byteAdr = bpu_byte_of(mem.bitAdr);
    mem.bitPos  = mem.bitAdr[2:0];
    mem.bitVal  = mem.rdByte[mem.bitAdr[2:0]];
    mem.wrByte  = mem.rdByte;
    mem.wrByte[mem.bitAdr[2:0]] = mem.wrVal;
  end
endmodule : bpu_bit_access

// File: hdl/bpu_mc_timer.sv
// Machine cycle tick generator
`timescale 1ns/10ps
module bpu_mc_timer
  import bpu_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  output logic      mcTick
);
  logic [3:0] cnt_q, cnt_d;
  always_comb begin
    cnt_d  = (cnt_q == MC_LAST) ? 4'h0 : cnt_q + 4'h1;
    mcTick = (cnt_q == MC_LAST);
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : bpu_mc_timer

// File: test/bpu_core_test.sv
// Self-checking bench for the bit processor and branch unit
`timescale 1ns/10ps
module bpu_core_test
  import bpu_pkg::*;
;
  // ==========================================
  // Stimulus and observation signals
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  logic        opValid = 1'b0;
  bpu_op_t     opCode  = OP_IDLE;
  logic [7:0]  opBitAdr = 8'h00, opRel = 8'h00, opByte = 8'h00, opByte2 = 8'h00;
  logic [7:0]  accIn = 8'h00;
  logic [15:0] opTarget = 16'h0000, pcNext = 16'h0000, ptrIn = 16'h0000, retAddr = 16'h0000;
  logic [7:0]  memRdata;
  logic        carryIn;
  logic        opReady, memWe, carryWe, carryOut, pcWe, pushPc, popPc, intDone, byteWe, done;
  logic [7:0]  memAddr, memWdata, byteOut;
  logic [15:0] pcOut;
  logic [7:0]  mem [256];
  int          numErrors = 0;
  int          samplesChecked = 0;
  int          cycles = 0;

  always #5 clk_sys = ~clk_sys;

  // Carry lives only in the status byte so both access paths stay coherent
  assign memRdata = mem[memAddr];
  assign carryIn  = mem[8'hD0][7];

  always @(posedge clk_sys) begin
    if (memWe === 1'b1) mem[memAddr] <= memWdata;
    if (carryWe === 1'b1) mem[8'hD0][7] <= carryOut;
  end

  bpu_core dut (
    .clk_sys, .rst_n, .opValid, .opCode, .opBitAdr, .opRel, .opTarget, .opByte, .opByte2,
    .pcNext, .accIn, .ptrIn, .retAddr, .memRdata, .carryIn, .opReady, .memAddr, .memWe,
    .memWdata, .carryWe, .carryOut, .pcWe, .pcOut, .pushPc, .popPc, .intDone, .byteWe,
    .byteOut, .done
  );

  // ==========================================
  // Reporting
  task automatic finish_test();
    if (numErrors == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic cmp_lat(input int lat, input int mc);
    samplesChecked++;
    if (lat < ((mc == 1) ? 1 : 13) || lat > mc * 12 + 14) begin
      numErrors++;
      $display("wrong value at %0t: latency %0d for %0d machine cycles", $time, lat, mc);
    end
  endtask : cmp_lat

  // Hang guard, well above 440 operations of at most 40 clocks
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      finish_test();
    end
  end

  // ==========================================
  // One operation against the reference model
  task automatic run_op(input bpu_op_t op);
    logic [7:0]  bAdr, rel, b1, b2, acc, ba, nb;
    logic [15:0] tgt, pn, ptr, ret, ePc;
    logic        b, c, eC, tk;
    int          n, mc;
    bAdr = 8'($urandom);
    rel  = ($urandom_range(3) == 0) ? ($urandom_range(1) ? 8'h80 : 8'h7F) : 8'($urandom);
    b1   = ($urandom_range(3) == 0) ? 8'h01 : 8'($urandom);
    b2   = ($urandom_range(2) == 0) ? b1 : 8'($urandom);
    acc  = ($urandom_range(2) == 0) ? 8'h00 : 8'($urandom);
    tgt  = 16'($urandom);
    pn   = 16'($urandom);
    ptr  = 16'($urandom);
    ret  = 16'($urandom);
    @(negedge clk_sys);
    cmp(16'(opReady), 16'h0001, "ready");
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= op;
    opBitAdr <= bAdr;
    opRel <= rel;
    opByte <= b1;
    opByte2 <= b2;
    accIn <= acc;
    opTarget <= tgt;
    pcNext <= pn;
    ptrIn <= ptr;
    retAddr <= ret;
    ba = bAdr[7] ? {bAdr[7:3], 3'h0} : 8'h20 + {3'h0, bAdr[7:3]};
    nb = mem[ba];
    b  = nb[bAdr[2:0]];
    c  = mem[8'hD0][7];
    eC = c;
    tk = 1'b0;
    ePc = pn;
    case (op)
      OP_AND_BIT:   eC = c & b;
      OP_AND_NBIT:  eC = c & ~b;
      OP_OR_BIT:    eC = c | b;
      OP_OR_NBIT:   eC = c | ~b;
      OP_MOV_C_BIT: eC = b;
      OP_MOV_BIT_C: nb[bAdr[2:0]] = c;
      OP_ZERO_C:    eC = 1'b0;
      OP_ZERO_BIT:  nb[bAdr[2:0]] = 1'b0;
      OP_ONE_C:     eC = 1'b1;
      OP_ONE_BIT:   nb[bAdr[2:0]] = 1'b1;
      OP_INV_C:     eC = ~c;
      OP_INV_BIT:   nb[bAdr[2:0]] = ~b;
      OP_JFS:       tk = c;
      OP_JFC:       tk = ~c;
      OP_JBS:       tk = b;
      OP_JBC:       tk = ~b;
      OP_JBCLR: begin
        tk = b;
        nb[bAdr[2:0]] = 1'b0;
      end
      OP_SHORT_RELATIVE_JUMP:      tk = 1'b1;
      OP_JZ:        tk = (acc == 8'h00);
      OP_JNZ:       tk = (acc != 8'h00);
      OP_DECREMENT_BRANCH:      tk = (b1 != 8'h01);
      OP_COMPARE_BRANCH_UNEQUAL: begin
        tk = (b1 != b2);
        eC = (b1 < b2);
      end
      OP_LONG_JUMP, OP_LONG_CALL: ePc = tgt;
      OP_PAGE_JUMP, OP_PAGE_CALL: ePc = {pn[15:11], tgt[10:0]};
      OP_JIDX:      ePc = ptr + {8'h00, acc};
      OP_RET, OP_INTERRUPT_EXIT: ePc = ret;
      default:      ePc = pn;
    endcase
    if (tk) ePc = pn + {{8{rel[7]}}, rel};
    if (ba == 8'hD0) begin
      if (eC != c) nb[7] = eC;
      else eC = nb[7];
    end
    mc = (op inside {OP_IDLE, OP_MOV_C_BIT, [OP_ZERO_C:OP_INV_BIT]}) ? 1 : 2;
    @(posedge clk_sys);
    opValid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 60);
    cmp_lat(n, mc);
    cmp((pcWe === 1'b1) ? pcOut : pn, ePc, "next pc");
    cmp(16'(pushPc), 16'(op inside {OP_LONG_CALL, OP_PAGE_CALL}), "push");
    cmp(16'(popPc), 16'(op inside {OP_RET, OP_INTERRUPT_EXIT}), "pop");
    cmp(16'(intDone), 16'(op == OP_INTERRUPT_EXIT), "int done");
    cmp(16'(byteWe), 16'(op == OP_DECREMENT_BRANCH), "byte write");
    if (op == OP_DECREMENT_BRANCH) cmp(16'(byteOut), 16'(b1 - 8'h01), "counter");
    @(posedge clk_sys);
    #1;
    cmp(16'(mem[ba]), 16'(nb), "bit byte");
    cmp(16'(mem[8'hD0][7]), 16'(eC), "carry");
  endtask : run_op

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'hA3490456));
    foreach (mem[i]) mem[i] = 8'($urandom);
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int i = 0; i <= 29; i++) run_op(bpu_op_t'(i));
    repeat (400) run_op(bpu_op_t'($urandom_range(29)));
    // Reset in mid-operation must abandon the request cleanly
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= OP_LONG_JUMP;
    @(posedge clk_sys);
    opValid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    cmp(16'(opReady), 16'h0001, "ready in reset");
    cmp(16'(done), 16'h0000, "done in reset");
    cmp(16'(pcWe), 16'h0000, "pc write in reset");
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (10) run_op(bpu_op_t'($urandom_range(29)));
    finish_test();
  end
endmodule : bpu_core_test
